// >>> tb.sv
// Self-checking bench for the UART FIFO control block
`timescale 1ns/10ps
module tb;
	localparam logic [7:0] DAT = uart_fifo_pkg::ADDR_DATA;
	localparam logic [7:0] FC  = uart_fifo_pkg::ADDR_FIFO_CONTROL;
	localparam logic [7:0] STA = uart_fifo_pkg::ADDR_INT_STATUS;
	localparam logic [7:0] MSK = uart_fifo_pkg::ADDR_INT_MASK;
	localparam logic [7:0] LVL = uart_fifo_pkg::ADDR_LEVEL;
	localparam int THR[4] = '{1, 4, 8, 14};
	logic        clk = 1'b0;
	logic        rst_b;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        tx_space_ready_n;
	logic        rx_data_ready_n;
	logic [7:0]  tx_char;
	logic        tx_char_valid;
	logic        tx_char_take;
	logic [7:0]  rx_char;
	logic        rx_char_valid;
	logic        rx_timeout;
	logic [31:0] rv;
	logic        last_err;
	logic [7:0]  tc;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cycles = 0;

	uart_fifo_control i_uart_fifo_control (
		.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq),
		.tx_space_ready_n(tx_space_ready_n),
		.rx_data_ready_n(rx_data_ready_n), .tx_char(tx_char),
		.tx_char_valid(tx_char_valid), .tx_char_take(tx_char_take),
		.rx_char(rx_char), .rx_char_valid(rx_char_valid),
		.rx_timeout(rx_timeout)
	);
	uart_shifter_model shifter (
		.clk(clk), .tx_char(tx_char), .tx_char_take(tx_char_take),
		.rx_char(rx_char), .rx_char_valid(rx_char_valid),
		.rx_timeout(rx_timeout)
	);

	always #12.5 clk = ~clk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string m);
		total_checks++;
		if (got !== exp) begin
			$display("unexpected %0t %s got %h", $time, m, got);
			fail_count++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One transfer, then an idle edge before the next setup
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rv = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic test_reset();
		chk(tx_space_ready_n, 1'b0, "tx pin");
		chk(rx_data_ready_n, 1'b1, "rx pin");
		chk(irq, 1'b0, "irq");
		rd(FC);
		chk(rv, 32'h0, "fc read");
		rd(LVL);
		chk(rv, 32'h0, "level");
		rd(8'h40);
		chk(last_err, 1'b1, "unmapped");
		$display("test reset done");
	endtask

	task automatic test_holding();
		wr(DAT, 32'hA5);
		wr(DAT, 32'h3C);
		tick(2);
		chk(tx_space_ready_n, 1'b1, "tx loaded");
		rd(LVL);
		chk(rv[12:8], 5'h01, "one slot");
		shifter.take(tc);
		chk(tc, 8'hA5, "tx char");
		tick(2);
		chk(tx_space_ready_n, 1'b0, "tx empty");
		shifter.send(8'h5A);
		shifter.send(8'h66);
		tick(2);
		chk(rx_data_ready_n, 1'b0, "rx held");
		rd(DAT);
		chk(rv[7:0], 8'h5A, "rx char");
		tick(2);
		chk(rx_data_ready_n, 1'b1, "rx gone");
		$display("test holding done");
	endtask

	task automatic test_gate();
		wr(FC, 32'hC8);
		rd(LVL);
		chk(rv[19:16], 4'h0, "gated");
		wr(FC, 32'hC9);
		rd(LVL);
		chk(rv[19:16], 4'hF, "taken");
		wr(FC, 32'hC8);
		rd(LVL);
		chk(rv[19:16], 4'hE, "enable only");
		$display("test gate done");
	endtask

	task automatic test_threshold();
		for (int i = 0; i < 4; i++) begin
			wr(FC, {24'h0, 2'(i), 6'h01});
			rd(STA);
			wr(MSK, 32'h1);
			for (int k = 1; k < THR[i]; k++)
				shifter.send(8'(k));
			tick(2);
			chk(irq, 1'b0, "below");
			shifter.send(8'hEE);
			tick(2);
			chk(irq, 1'b1, "at level");
			chk(rx_data_ready_n, 1'b0, "rx held");
			wr(MSK, 32'h0);
			chk(irq, 1'b0, "masked");
			wr(MSK, 32'h1);
			chk(irq, 1'b1, "unmasked");
			rd(STA);
			chk(rv[0], 1'b1, "status");
			chk(irq, 1'b0, "read clears");
			if (i == 3) begin
				for (int k = 0; k < 3; k++)
					shifter.send(8'h77);
				rd(LVL);
				chk(rv[4:0], 5'h10, "full");
			end
			wr(FC, {24'h0, 2'(i), 6'h03});
			rd(LVL);
			chk(rv[4:0], 5'h00, "rx cleared");
			tick(2);
			chk(rx_data_ready_n, 1'b1, "rx empty");
		end
		$display("test threshold done");
	endtask

	task automatic test_mode1();
		wr(FC, 32'h49);
		for (int k = 0; k < 3; k++)
			shifter.send(8'(k));
		tick(2);
		chk(rx_data_ready_n, 1'b1, "below");
		shifter.send(8'h33);
		tick(2);
		chk(rx_data_ready_n, 1'b0, "reached");
		for (int k = 0; k < 3; k++)
			rd(DAT);
		tick(2);
		chk(rx_data_ready_n, 1'b0, "stays");
		rd(DAT);
		chk(rv[7:0], 8'h33, "last");
		tick(2);
		chk(rx_data_ready_n, 1'b1, "emptied");
		shifter.send(8'h11);
		tick(2);
		chk(rx_data_ready_n, 1'b1, "one char");
		shifter.time_out();
		tick(2);
		chk(rx_data_ready_n, 1'b0, "time-out");
		rd(DAT);
		tick(2);
		chk(rx_data_ready_n, 1'b1, "drained");
		chk(tx_space_ready_n, 1'b0, "tx empty");
		for (int k = 0; k < 16; k++)
			wr(DAT, 32'(k));
		tick(2);
		chk(tx_space_ready_n, 1'b1, "tx full");
		for (int k = 0; k < 16; k++) begin
			shifter.take(tc);
			chk(tc, 8'(k), "order");
		end
		tick(2);
		chk(tx_space_ready_n, 1'b0, "tx drained");
		$display("test mode1 done");
	endtask

	task automatic test_clear();
		for (int k = 0; k < 3; k++)
			wr(DAT, 32'h55);
		shifter.send(8'h21);
		shifter.send(8'h22);
		wr(FC, 32'h4D);
		rd(LVL);
		chk(rv[12:8], 5'h00, "tx cleared");
		chk(rv[4:0], 5'h02, "rx kept");
		chk(rv[19:16], 4'h7, "fields kept");
		chk(tx_char_valid, 1'b0, "no tx head");
		$display("test clear done");
	endtask

	task automatic test_events();
		wr(MSK, 32'h0);
		wr(FC, 32'h07);
		rd(STA);
		rd(STA);
		chk(rv[3:0], 4'h0, "quiet");
		shifter.time_out();
		rd(STA);
		chk(rv[3:0], 4'h0, "idle time-out");
		wr(MSK, 32'h2);
		shifter.send(8'h41);
		shifter.time_out();
		tick(2);
		chk(irq, 1'b1, "time-out irq");
		wr(DAT, 32'h42);
		shifter.take(tc);
		for (int k = 0; k < 16; k++)
			shifter.send(8'(k));
		rd(LVL);
		chk(rv[4:0], 5'h10, "full");
		rd(STA);
		chk(rv[3:0], 4'hF, "all events");
		rd(STA);
		chk(rv[3:0], 4'h0, "read cleared");
		chk(irq, 1'b0, "irq cleared");
		$display("test events done");
	endtask

	initial begin
		rst_b <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		test_reset();
		test_holding();
		test_gate();
		test_threshold();
		test_mode1();
		test_clear();
		test_events();
		finish_test();
	end
endmodule

// >>> uart_byte_fifo.sv
// Circular byte store with clear, used for both directions
`timescale 1ns/10ps
module uart_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             clr,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] rdata,
	output logic      [CNT_W-1:0] count
);
	localparam int PTR_W = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	wire              do_push;
	wire              do_pop;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
	endfunction

	assign do_push = push && (count != CNT_W'(DEPTH));
	assign do_pop  = pop && (count != '0);
	assign rdata   = mem[rd_ptr];

	always_ff @(posedge clk) begin
		if (do_push && !clr)
			mem[wr_ptr] <= wdata;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else if (clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_push)
				wr_ptr <= ptr_inc(wr_ptr);
			if (do_pop)
				rd_ptr <= ptr_inc(rd_ptr);
			if (do_push && !do_pop)
				count <= count + CNT_W'(1);
			else if (do_pop && !do_push)
				count <= count - CNT_W'(1);
		end
	end
endmodule

// >>> uart_fifo_control.sv
// FIFO control, APB registers and ready pins of the UART
//
// Overview of operation
// - A two-bit field at bits 7:6 sets the receive threshold; hitting it raises the receive interrupt.
// - Past the threshold, received characters keep filling the FIFO until it is full.
// - The ready mode bit selects mode zero when clear (reset value) and mode one when set while the enable bit is also set.
// - In mode zero the transmit-ready pin is low while no character is held and high after one is written.
// - In mode zero the receive-ready pin is low while a character is held and high once none remain.
// - In mode one the transmit-ready pin is high when the FIFO is full and low when it is empty.
// - In mode one receive-ready goes low at threshold or time-out and stays low until the FIFO empties.
// - Writing one to the transmit clear bit empties the transmit FIFO, leaving the shifter alone.
// - Writing one to the receive clear bit empties the receive FIFO, leaving the shifter alone.
// - The enable bit turns on both FIFOs; clear (reset value) gives single-character holding.
// - Other control bits are only taken by a write that also sets the enable bit.
// - Threshold codes 00, 01, 10, 11 give 1, 4, 8 and 14 bytes.
`timescale 1ns/10ps
module uart_fifo_control #(
	parameter int DEPTH = uart_fifo_pkg::FIFO_DEPTH
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             irq,
	output logic             tx_space_ready_n,
	output logic             rx_data_ready_n,
	output logic      [7:0]  tx_char,
	output logic             tx_char_valid,
	input  wire logic        tx_char_take,
	input  wire logic [7:0]  rx_char,
	input  wire logic        rx_char_valid,
	input  wire logic        rx_timeout
);
	localparam int CW = uart_fifo_pkg::CNT_W;
	localparam int EW = uart_fifo_pkg::EV_W;

	logic          fifo_en;
	logic          ready_mode;
	logic [1:0]    thr_field;
	logic [EW-1:0] int_status;
	logic [EW-1:0] int_mask;
	logic [EW-1:0] next_status;
	logic [EW-1:0] rd_status;
	logic          rd_had_data;
	logic          tx_empty_prev;
	logic          level_prev;
	logic [CW-1:0] tx_count;
	logic [CW-1:0] rx_count;
	logic [7:0]    rx_head;

	// Bus decode
	wire setup   = psel && !penable;
	wire access  = psel && penable;
	wire hit_data  = (paddr == uart_fifo_pkg::ADDR_DATA);
	wire hit_fcr   = (paddr == uart_fifo_pkg::ADDR_FIFO_CONTROL);
	wire hit_stat  = (paddr == uart_fifo_pkg::ADDR_INT_STATUS);
	wire hit_mask  = (paddr == uart_fifo_pkg::ADDR_INT_MASK);
	wire hit_level = (paddr == uart_fifo_pkg::ADDR_LEVEL);
	wire addr_ok   = hit_data || hit_fcr || hit_stat || hit_mask
		|| hit_level;
	wire wr_en   = access && pwrite && addr_ok;
	wire rd_en   = access && !pwrite && addr_ok;
	wire fcr_wr  = wr_en && hit_fcr;
	wire wr_enable = pwdata[uart_fifo_pkg::FIFO_ENABLE_POS];

	wire fcr_take = fcr_wr && wr_enable;
	wire tx_clear = fcr_take && pwdata[uart_fifo_pkg::TX_CLEAR_POS];
	wire rx_clear = fcr_take && pwdata[uart_fifo_pkg::RX_CLEAR_POS];
	wire en_change = fcr_wr && (wr_enable != fifo_en);
	wire tx_flush  = tx_clear || en_change;
	wire rx_flush  = rx_clear || en_change;

	wire [CW-1:0] capacity = fifo_en ? CW'(DEPTH) : CW'(1);
	wire tx_full  = (tx_count >= capacity);
	wire rx_full  = (rx_count >= capacity);
	wire tx_push  = wr_en && hit_data && !tx_full;
	wire rx_push  = rx_char_valid && !rx_full;
	wire rx_pop   = rd_en && hit_data && rd_had_data;
	wire tx_pop   = tx_char_take && tx_char_valid;

	wire [CW-1:0] rx_thr = fifo_en
		? uart_fifo_pkg::thr_decode(thr_field) : CW'(1);
	wire level_hit = (rx_count == rx_thr);
	wire tx_empty  = (tx_count == '0);

	wire [EW-1:0] events;
	assign events[uart_fifo_pkg::EV_RX_LEVEL]   = level_hit && !level_prev;
	assign events[uart_fifo_pkg::EV_RX_TIMEOUT] = rx_timeout
		&& (rx_count != '0);
	assign events[uart_fifo_pkg::EV_TX_EMPTY]   = tx_empty && !tx_empty_prev;
	assign events[uart_fifo_pkg::EV_RX_OVERRUN] = rx_char_valid && rx_full;

	wire [31:0] level_word = 32'(rx_count) << uart_fifo_pkg::LEVEL_RX_LSB
		| 32'(tx_count) << uart_fifo_pkg::LEVEL_TX_LSB
		| 32'(fifo_en) << uart_fifo_pkg::LEVEL_EN_POS
		| 32'(ready_mode) << uart_fifo_pkg::LEVEL_MODE_POS
		| 32'(thr_field) << uart_fifo_pkg::LEVEL_THR_LSB;
	wire [31:0] rd_mux = hit_data ? 32'(rx_head)
		: hit_stat  ? 32'(int_status)
		: hit_mask  ? 32'(int_mask)
		: hit_level ? level_word
		: 32'h0000_0000;
	wire clr_status = rd_en && hit_stat;

	assign pready  = 1'b1;
	assign pslverr = access && !addr_ok;
	assign irq     = |(int_status & int_mask);
	assign tx_char_valid = !tx_empty;

	// Read clears only bits already returned; new events win
	always_comb begin
		next_status = int_status;
		if (clr_status)
			next_status = int_status & ~rd_status;
		next_status = next_status | events;
	end

	uart_byte_fifo #(
		.WIDTH (uart_fifo_pkg::DATA_W),
		.DEPTH (DEPTH),
		.CNT_W (CW)
	) tx_fifo (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (tx_flush),
		.push  (tx_push),
		.wdata (pwdata[7:0]),
		.pop   (tx_pop),
		.rdata (tx_char),
		.count (tx_count)
	);

	uart_byte_fifo #(
		.WIDTH (uart_fifo_pkg::DATA_W),
		.DEPTH (DEPTH),
		.CNT_W (CW)
	) rx_fifo (
		.clk   (clk),
		.rst_b (rst_b),
		.clr   (rx_flush),
		.push  (rx_push),
		.wdata (rx_char),
		.pop   (rx_pop),
		.rdata (rx_head),
		.count (rx_count)
	);

	uart_ready_pins #(
		.DEPTH (DEPTH),
		.CNT_W (CW)
	) ready_pins (
		.clk              (clk),
		.rst_b            (rst_b),
		.fifo_en          (fifo_en),
		.ready_mode       (ready_mode),
		.tx_count         (tx_count),
		.rx_count         (rx_count),
		.rx_thr           (rx_thr),
		.rx_timeout       (rx_timeout),
		.tx_space_ready_n (tx_space_ready_n),
		.rx_data_ready_n  (rx_data_ready_n)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fifo_en    <= uart_fifo_pkg::FIFO_ENABLE_RESET;
			ready_mode <= uart_fifo_pkg::READY_MODE_RESET;
			thr_field  <= uart_fifo_pkg::RX_THR_RESET;
		end else if (fcr_wr) begin
			fifo_en <= wr_enable;
			if (wr_enable) begin
				ready_mode <= pwdata[uart_fifo_pkg::READY_MODE_POS];
				thr_field  <= pwdata[uart_fifo_pkg::RX_THR_MSB:
					uart_fifo_pkg::RX_THR_LSB];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			int_status    <= uart_fifo_pkg::INT_STATUS_RESET;
			int_mask      <= uart_fifo_pkg::INT_MASK_RESET;
			tx_empty_prev <= 1'b1;
			level_prev    <= 1'b0;
		end else begin
			int_status    <= next_status;
			tx_empty_prev <= tx_empty;
			level_prev    <= level_hit;
			if (wr_en && hit_mask)
				int_mask <= pwdata[EW-1:0];
		end
	end

	// Read data captured in the setup cycle
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata      <= 32'h0000_0000;
			rd_status   <= '0;
			rd_had_data <= 1'b0;
		end else if (setup) begin
			prdata      <= pwrite ? 32'h0000_0000 : rd_mux;
			rd_status   <= int_status;
			rd_had_data <= (rx_count != '0);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_RX_THRESHOLD_EVENT: assert property (
		fifo_en && level_hit && !level_prev
		|=> int_status[uart_fifo_pkg::EV_RX_LEVEL])
		else $error("threshold hit did not set status");
	AST_RX_KEEPS_FILLING: assert property (
		fifo_en && rx_char_valid && rx_count >= rx_thr
		&& rx_count < CW'(DEPTH) && !rx_flush && !rx_pop && !fcr_wr
		|=> rx_count == $past(rx_count) + CW'(1))
		else $error("receive FIFO stopped filling above threshold");
	AST_MODE_TAKEN: assert property (
		fcr_take |=> ready_mode == $past(pwdata[3]))
		else $error("ready mode not taken");
	AST_TX_READY_MODE0: assert property (
		!(fifo_en && ready_mode) && tx_empty && !tx_push
		|=> !tx_space_ready_n)
		else $error("transmit ready not low when empty");
	AST_RX_READY_MODE0: assert property (
		!(fifo_en && ready_mode) && rx_count != '0
		|=> !rx_data_ready_n)
		else $error("receive ready not low with data held");
	AST_TX_READY_FULL: assert property (
		fifo_en && ready_mode && tx_count == CW'(DEPTH)
		|=> tx_space_ready_n)
		else $error("transmit ready not high when full");
	AST_RX_READY_HOLD: assert property (
		fifo_en && ready_mode && !rx_data_ready_n && rx_count != '0
		&& $past(fifo_en) && $past(ready_mode)
		&& !fcr_wr |=> !rx_data_ready_n)
		else $error("receive ready released before empty");
	AST_TX_CLEAR: assert property (
		tx_clear |=> tx_count == '0)
		else $error("transmit clear left data");
	AST_RX_CLEAR: assert property (
		rx_clear |=> rx_count == '0)
		else $error("receive clear left data");
	AST_HOLDING_ONLY: assert property (
		!fifo_en |-> tx_count <= CW'(1) && rx_count <= CW'(1))
		else $error("more than one character held with FIFOs off");
	AST_WRITE_IGNORED: assert property (
		fcr_wr && !wr_enable
		|=> $stable(ready_mode) && $stable(thr_field))
		else $error("control bits taken without enable");
	AST_THRESHOLD_CODE: assert property (
		fcr_take && pwdata[7:6] == 2'h3 |=> fifo_en ##0 rx_thr == 5'h0E)
		else $error("threshold code 11 not 14 bytes");

	AST_STATUS_STICKY: assert property (
		!clr_status
		|=> (int_status & $past(int_status)) == $past(int_status))
		else $error("status bit lost without a read");
	AST_READ_CLEARS: assert property (
		clr_status && (rd_status & events) == '0
		|=> (int_status & $past(rd_status)) == '0)
		else $error("status read did not clear returned bits");
	AST_EVENT_SETS: assert property (
		events != '0
		|=> (int_status & $past(events)) == $past(events))
		else $error("event did not set its status bit");
	AST_UNMAPPED_NO_EFFECT: assert property (
		access && !addr_ok |=> $stable(fifo_en) && $stable(ready_mode)
		&& $stable(thr_field) && $stable(int_mask))
		else $error("unmapped access changed a register");
	AST_TX_FULL_DROP: assert property (
		tx_full && wr_en && hit_data && !tx_pop && !tx_flush
		|=> tx_count == $past(tx_count))
		else $error("write into full transmit store was taken");
	AST_RX_OVERRUN_DROP: assert property (
		rx_char_valid && rx_full && !rx_pop && !rx_flush
		|=> rx_count == $past(rx_count))
		else $error("receive store grew past its capacity");
	AST_RX_PUSH_COUNT: assert property (
		rx_push && !rx_pop && !rx_flush
		|=> rx_count == $past(rx_count) + CW'(1))
		else $error("received character not counted");
	AST_TX_PUSH_COUNT: assert property (
		tx_push && !tx_pop && !tx_flush
		|=> tx_count == $past(tx_count) + CW'(1))
		else $error("transmit write not counted");
	AST_TX_POP_COUNT: assert property (
		tx_pop && !tx_push && !tx_flush
		|=> tx_count == $past(tx_count) - CW'(1))
		else $error("transmit take not counted");
	AST_RX_POP_COUNT: assert property (
		rx_pop && !rx_push && !rx_flush
		|=> rx_count == $past(rx_count) - CW'(1))
		else $error("receive read not counted");
	AST_ENABLE_FLUSH: assert property (
		en_change
		|=> tx_count == '0 && rx_count == '0)
		else $error("enable change left data behind");
	AST_TX_CLEAR_KEEPS_RX: assert property (
		tx_clear && !rx_flush && !rx_push && !rx_pop
		|=> rx_count == $past(rx_count))
		else $error("transmit clear disturbed the receive store");
	AST_RX_CLEAR_KEEPS_TX: assert property (
		rx_clear && !tx_flush && !tx_push && !tx_pop
		|=> tx_count == $past(tx_count))
		else $error("receive clear disturbed the transmit store");
	AST_RX_READY_REACHED: assert property (
		fifo_en && ready_mode && rx_count >= rx_thr
		|=> !rx_data_ready_n)
		else $error("receive ready not low at threshold");
	AST_RX_READY_EMPTY: assert property (
		fifo_en && ready_mode && rx_count == '0
		|=> rx_data_ready_n)
		else $error("receive ready not high once emptied");
	AST_TX_READY_EMPTY: assert property (
		fifo_en && ready_mode && tx_empty
		|=> !tx_space_ready_n)
		else $error("transmit ready not low when empty");
	AST_RX_READY_IDLE: assert property (
		!(fifo_en && ready_mode) && rx_count == '0
		|=> rx_data_ready_n)
		else $error("receive ready low with nothing held");

	COV_BLOCK_RX: cover property (
		fifo_en && ready_mode && $fell(rx_data_ready_n));
	COV_TX_FULL: cover property (fifo_en && tx_count == CW'(DEPTH));
	COV_OVERRUN: cover property (events[uart_fifo_pkg::EV_RX_OVERRUN]);
	COV_IRQ: cover property ($rose(irq));
	COV_RX_TIMEOUT: cover property (events[uart_fifo_pkg::EV_RX_TIMEOUT]);
endmodule

// >>> uart_fifo_pkg.sv
// Shared constants and types for the UART FIFO control block
package uart_fifo_pkg;
	localparam int FIFO_DEPTH = 16;
	localparam int DATA_W     = 8;
	localparam int CNT_W      = 5;
	localparam int EV_W       = 4;

	localparam logic [7:0] ADDR_DATA         = 8'h00;
	localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_INT_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK     = 8'h0C;
	localparam logic [7:0] ADDR_LEVEL        = 8'h10;

	localparam int FIFO_ENABLE_POS = 0;
	localparam int RX_CLEAR_POS    = 1;
	localparam int TX_CLEAR_POS    = 2;
	localparam int READY_MODE_POS  = 3;
	localparam int RX_THR_LSB      = 6;
	localparam int RX_THR_MSB      = 7;

	localparam int LEVEL_RX_LSB    = 0;
	localparam int LEVEL_TX_LSB    = 8;
	localparam int LEVEL_EN_POS    = 16;
	localparam int LEVEL_MODE_POS  = 17;
	localparam int LEVEL_THR_LSB   = 18;

	localparam int EV_RX_LEVEL   = 0;
	localparam int EV_RX_TIMEOUT = 1;
	localparam int EV_TX_EMPTY   = 2;
	localparam int EV_RX_OVERRUN = 3;

	localparam logic            FIFO_ENABLE_RESET = 1'b0;
	localparam logic            READY_MODE_RESET  = 1'b0;
	localparam logic [1:0]      RX_THR_RESET      = 2'h0;
	localparam logic [EV_W-1:0] INT_MASK_RESET    = 4'h0;
	localparam logic [EV_W-1:0] INT_STATUS_RESET  = 4'h0;

	localparam logic [CNT_W-1:0] THR_CODE0 = 5'h01;
	localparam logic [CNT_W-1:0] THR_CODE1 = 5'h04;
	localparam logic [CNT_W-1:0] THR_CODE2 = 5'h08;
	localparam logic [CNT_W-1:0] THR_CODE3 = 5'h0E;

	typedef enum logic [1:0] {
		RX_WAIT  = 2'b01,
		RX_DRAIN = 2'b10
	} rx_ready_state_type;

	function automatic logic [CNT_W-1:0] thr_decode(input logic [1:0] code);
		case (code)
			2'h0:    thr_decode = THR_CODE0;
			2'h1:    thr_decode = THR_CODE1;
			2'h2:    thr_decode = THR_CODE2;
			default: thr_decode = THR_CODE3;
		endcase
	endfunction
endpackage

// >>> uart_ready_pins.sv
// Transmit-ready and receive-ready pin generation for both modes
`timescale 1ns/10ps
module uart_ready_pins #(
	parameter int DEPTH = 16,
	parameter int CNT_W = 5
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             fifo_en,
	input  wire logic             ready_mode,
	input  wire logic [CNT_W-1:0] tx_count,
	input  wire logic [CNT_W-1:0] rx_count,
	input  wire logic [CNT_W-1:0] rx_thr,
	input  wire logic             rx_timeout,
	output logic                  tx_space_ready_n,
	output logic                  rx_data_ready_n
);
	uart_fifo_pkg::rx_ready_state_type state;
	uart_fifo_pkg::rx_ready_state_type next_state;
	logic                              next_tx_n;
	wire                               block_mode;
	wire                               rx_start;

	assign block_mode = fifo_en && ready_mode;
	assign rx_start   = (rx_count >= rx_thr)
		|| (rx_timeout && (rx_count != '0));

	always_comb begin
		next_state = state;
		case (state)
			uart_fifo_pkg::RX_WAIT: begin
				if (block_mode && rx_start)
					next_state = uart_fifo_pkg::RX_DRAIN;
			end
			uart_fifo_pkg::RX_DRAIN: begin
				if (!block_mode || rx_count == '0)
					next_state = uart_fifo_pkg::RX_WAIT;
			end
			default: next_state = uart_fifo_pkg::RX_WAIT;
		endcase
	end

	always_comb begin
		next_tx_n = tx_space_ready_n;
		if (!block_mode)
			// high once a character is held
			next_tx_n = (tx_count != '0);
		// full high, empty low, else hold
		else if (tx_count == CNT_W'(DEPTH))
			next_tx_n = 1'b1;
		else if (tx_count == '0)
			next_tx_n = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state            <= uart_fifo_pkg::RX_WAIT;
			tx_space_ready_n <= 1'b0;
			rx_data_ready_n  <= 1'b1;
		end else begin
			state            <= next_state;
			tx_space_ready_n <= next_tx_n;
			// mode zero: low while any character is held; mode one: low while in RX_DRAIN
			rx_data_ready_n  <= block_mode
				? (next_state != uart_fifo_pkg::RX_DRAIN)
				: (rx_count == '0);
		end
	end
endmodule

// >>> uart_shifter_model.sv
// Shifter-side model: receive pushes, time-outs and transmit pops
`timescale 1ns/10ps
module uart_shifter_model (
	input  wire logic       clk,
	input  wire logic [7:0] tx_char,
	output logic            tx_char_take,
	output logic      [7:0] rx_char,
	output logic            rx_char_valid,
	output logic            rx_timeout
);
	initial begin
		tx_char_take = 1'b0;
		rx_char = 8'h00;
		rx_char_valid = 1'b0;
		rx_timeout = 1'b0;
	end
	// Data line scrambled outside the pulse
	task automatic send(input logic [7:0] c);
		rx_char <= c;
		rx_char_valid <= 1'b1;
		@(posedge clk);
		rx_char <= ~c;
		rx_char_valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic take(output logic [7:0] c);
		tx_char_take <= 1'b1;
		@(posedge clk);
		c = tx_char;
		tx_char_take <= 1'b0;
		@(posedge clk);
	endtask
	task automatic time_out();
		rx_timeout <= 1'b1;
		@(posedge clk);
		rx_timeout <= 1'b0;
		@(posedge clk);
	endtask
endmodule
